// ---- design/tref_defs.svh ----
`ifndef TREF_DEFS_SVH
`define TREF_DEFS_SVH

// ****************************************
// clock and timing
// ****************************************
`define TREF_CLK_HZ 100000000
`define TREF_LOS_TIME_MS 100
`define TREF_BER_TIME_MS 2500
`define TREF_HOLDOFF_TIME_S 10
`define TREF_LOS_CYCLES (`TREF_CLK_HZ / 1000 * `TREF_LOS_TIME_MS)
`define TREF_BER_CYCLES (`TREF_CLK_HZ / 1000 * `TREF_BER_TIME_MS)
`define TREF_HOLDOFF_CYCLES (`TREF_CLK_HZ * `TREF_HOLDOFF_TIME_S)

// ****************************************
// reason field bit positions
// ****************************************
`define TREF_RSN_PHASE 0
`define TREF_RSN_LOS 1
`define TREF_RSN_BER 2
`define TREF_RSN_JITTER 3
`define TREF_RSN_W 4

// ****************************************
// frequency steering
// ****************************************
`define TREF_FREQ_W 16
`define TREF_SLEW_CYCLES 1000
`define TREF_FREQ_NOMINAL 16'h0000

`endif

// ---- design/tref_pkg.sv ----
package tref_pkg;
  // ****************************************
  // selector states
  // ****************************************
  typedef enum logic [1:0] {
    ST_TRACK = 2'b01,
    ST_FREE = 2'b10
  } sel_state_t;
endpackage

// ---- design/timing_reference_selector.sv ----
// What this block does
// - failed active reference switches to backup
// - all references failed enters free-run
// - no reselection within 10 s hold-off
// - 1000 ns phase hit, low slope triggers
// - all-zeros for 0.10 s triggers switch
// - 1e-3 error rate for 2.5 s triggers
// - excessive input jitter triggers switch
// - rearrangements request phase build-out, no jumps
// - frequency word slews at limited rate
// - loop-timed mode may stop transmit when lost
`include "tref_defs.svh"

module timing_reference_selector #(
  parameter int NUM_REFS = 4,
  parameter int SEL_W = 2,
  parameter int LOS_CYCLES = `TREF_LOS_CYCLES,
  parameter int BER_CYCLES = `TREF_BER_CYCLES,
  parameter int HOLDOFF_CYCLES = `TREF_HOLDOFF_CYCLES,
  parameter int SLEW_CYCLES = `TREF_SLEW_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // configuration
  input wire logic [NUM_REFS-1:0] i_ref_enable,
  input wire logic [SEL_W-1:0] i_primary,
  input wire logic i_loop_timed,
  input wire logic i_mode_change,
  // trunk receiver conditions, asynchronous
  input wire logic [NUM_REFS-1:0] i_phase_hit,
  input wire logic [NUM_REFS-1:0] i_slope_ok,
  input wire logic [NUM_REFS-1:0] i_all_zeros,
  input wire logic [NUM_REFS-1:0] i_ber_high,
  input wire logic [NUM_REFS-1:0] i_jitter_high,
  // phase detector steering from the loop
  input wire logic signed [`TREF_FREQ_W-1:0] i_steer,
  // selection and clock control
  output logic [SEL_W-1:0] o_active,
  output logic o_free_run,
  output logic o_build_out,
  output logic signed [`TREF_FREQ_W-1:0] o_freq_word,
  output logic o_tx_enable,
  // status
  output logic [NUM_REFS-1:0] o_ref_failed,
  output logic [`TREF_RSN_W-1:0] o_switch_reason,
  output logic o_switched
);
  import tref_pkg::*;

  localparam int CNT_W = 32;
  localparam int NIN = 5;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NIN*NUM_REFS-1:0] raw_in;
  logic [NIN*NUM_REFS-1:0] sync1;
  logic [NIN*NUM_REFS-1:0] sync2;
  logic [NIN*NUM_REFS-1:0] sync3;
  logic [NIN*NUM_REFS-1:0] filt;

  assign raw_in = {i_phase_hit, i_slope_ok, i_all_zeros, i_ber_high,
                   i_jitter_high};

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else if (i_ce)
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      filt <= '0;
    else if (i_ce)
      filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
  end

  logic [NUM_REFS-1:0] s_jit;
  logic [NUM_REFS-1:0] s_ber;
  logic [NUM_REFS-1:0] s_zero;
  logic [NUM_REFS-1:0] s_slope;
  logic [NUM_REFS-1:0] s_hit;
  assign {s_hit, s_slope, s_zero, s_ber, s_jit} = filt;

  // ****************************************
  // per-reference qualification
  // ****************************************
  logic [CNT_W-1:0] los_cnt [NUM_REFS];
  logic [CNT_W-1:0] ber_cnt [NUM_REFS];
  logic [`TREF_RSN_W-1:0] fail_rsn [NUM_REFS];
  logic [NUM_REFS-1:0] healthy;

  function automatic logic [CNT_W-1:0] dur_count(
    input logic cond, input logic [CNT_W-1:0] cnt, input int lim);
    if (!cond)
      dur_count = '0;
    else if (cnt < CNT_W'(lim))
      dur_count = cnt + CNT_W'(1);
    else
      dur_count = cnt;
  endfunction

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      for (int i = 0; i < NUM_REFS; i++)
      begin
        los_cnt[i] <= '0;
        ber_cnt[i] <= '0;
      end
    end
    else if (i_ce)
    begin
      for (int i = 0; i < NUM_REFS; i++)
      begin
        los_cnt[i] <= dur_count(s_zero[i], los_cnt[i], LOS_CYCLES);
        ber_cnt[i] <= dur_count(s_ber[i], ber_cnt[i], BER_CYCLES);
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_REFS; i++)
    begin
      fail_rsn[i] = '0;
      fail_rsn[i][`TREF_RSN_PHASE] = s_hit[i] & s_slope[i];
      fail_rsn[i][`TREF_RSN_LOS] = (los_cnt[i] >= CNT_W'(LOS_CYCLES));
      fail_rsn[i][`TREF_RSN_BER] = (ber_cnt[i] >= CNT_W'(BER_CYCLES));
      fail_rsn[i][`TREF_RSN_JITTER] = s_jit[i];
      healthy[i] = i_ref_enable[i] & ~(|fail_rsn[i]);
    end
  end

  // first healthy reference after the given one, wrapping
  function automatic logic [SEL_W:0] pick_next(
    input logic [NUM_REFS-1:0] ok, input logic [SEL_W-1:0] from);
    int idx;
    pick_next = '0;
    for (int k = NUM_REFS; k >= 1; k--)
    begin
      idx = (int'(from) + k) % NUM_REFS;
      if (ok[idx])
        pick_next = {1'b1, SEL_W'(idx)};
    end
  endfunction

  // ****************************************
  // selection state machine
  // ****************************************
  sel_state_t state;
  logic [CNT_W-1:0] holdoff;
  logic holdoff_done;
  logic [SEL_W:0] next_pick;
  logic [SEL_W:0] prim_pick;
  logic active_bad;

  assign holdoff_done = (holdoff == '0);
  assign next_pick = pick_next(healthy, o_active);
  assign prim_pick = {healthy[i_primary], i_primary};
  assign active_bad = ~healthy[o_active];

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state <= ST_FREE;
      o_active <= '0;
      o_free_run <= 1'b1;
      o_switched <= 1'b0;
      o_switch_reason <= '0;
      holdoff <= '0;
    end
    else if (i_ce)
    begin
      o_switched <= 1'b0;
      if (!holdoff_done)
        holdoff <= holdoff - CNT_W'(1);
      unique case (state)
        ST_TRACK:
        begin
          if (active_bad && !next_pick[SEL_W])
          begin
            state <= ST_FREE;
            o_free_run <= 1'b1;
            o_switched <= 1'b1;
            o_switch_reason <= fail_rsn[o_active];
            holdoff <= CNT_W'(HOLDOFF_CYCLES);
          end
          else if (active_bad && holdoff_done)
          begin
            o_active <= next_pick[SEL_W-1:0];
            o_switched <= 1'b1;
            o_switch_reason <= fail_rsn[o_active];
            holdoff <= CNT_W'(HOLDOFF_CYCLES);
          end
        end
        ST_FREE:
        begin
          if (holdoff_done && (prim_pick[SEL_W] || next_pick[SEL_W]))
          begin
            state <= ST_TRACK;
            o_free_run <= 1'b0;
            o_active <= prim_pick[SEL_W] ? i_primary
                                         : next_pick[SEL_W-1:0];
            o_switched <= 1'b1;
            o_switch_reason <= '0;
            holdoff <= CNT_W'(HOLDOFF_CYCLES);
          end
        end
      endcase
    end
  end

  // ****************************************
  // phase build-out and frequency slew
  // ****************************************
  logic [CNT_W-1:0] slew_cnt;
  logic signed [`TREF_FREQ_W-1:0] target;

  assign target = o_free_run ? `TREF_FREQ_NOMINAL : i_steer;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_build_out <= 1'b0;
    else if (i_ce)
      o_build_out <= o_switched | i_mode_change;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      slew_cnt <= '0;
      o_freq_word <= `TREF_FREQ_NOMINAL;
    end
    else if (i_ce)
    begin
      if (slew_cnt >= CNT_W'(SLEW_CYCLES - 1))
      begin
        slew_cnt <= '0;
        if (o_freq_word < target)
          o_freq_word <= o_freq_word + `TREF_FREQ_W'(1);
        else if (o_freq_word > target)
          o_freq_word <= o_freq_word - `TREF_FREQ_W'(1);
      end
      else
        slew_cnt <= slew_cnt + CNT_W'(1);
    end
  end

  // ****************************************
  // status and transmit enable
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_ref_failed <= '0;
      o_tx_enable <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ref_failed <= ~healthy;
      o_tx_enable <= ~(i_loop_timed & o_free_run);
    end
  end

endmodule // timing_reference_selector

// ---- bench/tref_checker.sv ----
module tref_checker #(
  parameter int HOLDOFF_CYCLES = 100
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // watched inputs
  input wire logic i_loop_timed,
  input wire logic [3:0] i_jitter_high,
  // watched outputs
  input wire logic [1:0] o_active,
  input wire logic o_free_run,
  input wire logic o_build_out,
  input wire logic signed [15:0] o_freq_word,
  input wire logic o_tx_enable,
  input wire logic [3:0] o_ref_failed,
  input wire logic o_switched
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // cycles since last switch
  // ****
  int gap;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      gap <= HOLDOFF_CYCLES;
    else
      gap <= o_switched ? 0 : gap + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_pulse;
    o_switched ##1 o_build_out;
  endsequence
  property p_build;
    o_switched |-> s_pulse; endproperty
  a_build: assert property (p_build) else $error("no build-out");
  property p_sw;
    o_switched |-> o_active != $past(o_active) ||
      o_free_run != $past(o_free_run); endproperty
  a_sw: assert property (p_sw) else $error("idle switch flag");
  property p_gap;
    o_switched && !o_free_run |-> gap >= HOLDOFF_CYCLES - 2; endproperty
  a_gap: assert property (p_gap) else $error("switch in hold-off");
  property p_all;
    &o_ref_failed |-> ##[0:1] o_free_run; endproperty
  a_all: assert property (p_all) else $error("no free-run");
  property p_tx;
    !$past(i_reset) |->
      o_tx_enable == !($past(i_loop_timed) && $past(o_free_run));
  endproperty
  a_tx: assert property (p_tx) else $error("bad transmit enable");
  property p_step;
    !$past(i_reset) |->
      o_freq_word - $past(o_freq_word) inside {-1, 0, 1}; endproperty
  a_step: assert property (p_step) else $error("frequency jump");
  property p_slew;
    $changed(o_freq_word) && !$past(i_reset) |=>
      $stable(o_freq_word) [*3]; endproperty
  a_slew: assert property (p_slew) else $error("slew too fast");
  property p_jit;
    i_jitter_high[0] [*7] |-> o_ref_failed[0]; endproperty
  a_jit: assert property (p_jit) else $error("jitter not flagged");
endmodule // tref_checker

bind timing_reference_selector tref_checker #(
  .HOLDOFF_CYCLES(HOLDOFF_CYCLES)
) i_tref_checker (.i_clk, .i_reset, .i_loop_timed, .i_jitter_high,
  .o_active, .o_free_run, .o_build_out, .o_freq_word, .o_tx_enable,
  .o_ref_failed, .o_switched);

// ---- bench/trunk_model.sv ----
module trunk_model (
  // fault request
  input wire logic [15:0] i_fault,
  // receiver condition levels
  output logic [3:0] o_phase_hit,
  output logic [3:0] o_slope_ok,
  output logic [3:0] o_all_zeros,
  output logic [3:0] o_ber_high,
  output logic [3:0] o_jitter_high
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_jitter_high = i_fault[3:0];
  assign o_phase_hit = i_fault[7:4];
  assign o_slope_ok = i_fault[7:4];
  assign o_all_zeros = i_fault[11:8];
  assign o_ber_high = i_fault[15:12];
endmodule // trunk_model

// ---- bench/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic loop_timed = 1'h0;
  logic mode_change = 1'h0;
  logic [15:0] fault = 16'h0;
  logic signed [15:0] steer = 16'h3;
  logic ce = 1'h1;
  logic [3:0] ref_enable = 4'hF;
  logic [1:0] primary = 2'h0;
  logic [3:0] ph, sl, az, bh, jh, failed, reason;
  logic [1:0] active;
  logic signed [15:0] freq;
  logic free_run, build_out, tx_enable, switched;
  int num_errors = 0;
  int checks_done = 0;
  trunk_model i_trunk_model (.i_fault(fault), .o_phase_hit(ph),
    .o_slope_ok(sl), .o_all_zeros(az), .o_ber_high(bh),
    .o_jitter_high(jh));
  timing_reference_selector #(.LOS_CYCLES(20), .BER_CYCLES(50),
    .HOLDOFF_CYCLES(100), .SLEW_CYCLES(4)) i_timing_reference_selector (
    .i_clk(clk), .i_reset(reset), .i_ce(ce), .i_ref_enable(ref_enable),
    .i_primary(primary), .i_loop_timed(loop_timed),
    .i_mode_change(mode_change), .i_phase_hit(ph), .i_slope_ok(sl),
    .i_all_zeros(az), .i_ber_high(bh), .i_jitter_high(jh),
    .i_steer(steer), .o_active(active), .o_free_run(free_run),
    .o_build_out(build_out), .o_freq_word(freq),
    .o_tx_enable(tx_enable), .o_ref_failed(failed),
    .o_switch_reason(reason), .o_switched(switched));
  // ****
  // helpers
  // ****
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_jitter();
    fault[0] = 1'h1;
    cyc(20);
    chk("active", active, 16'h0);
    cyc(90);
    chk("active", active, 16'h1);
    chk("reason", reason, 16'h8);
    chk("failed", failed, 16'h1);
  endtask
  task automatic t_hit();
    fault[5] = 1'h1;
    cyc(110);
    chk("active", active, 16'h2);
    chk("reason", reason, 16'h1);
  endtask
  task automatic t_los();
    fault[10] = 1'h1;
    cyc(20);
    chk("failed", failed, 16'h3);
    cyc(90);
    chk("active", active, 16'h3);
    chk("reason", reason, 16'h2);
  endtask
  task automatic t_ber();
    fault[15] = 1'h1;
    loop_timed = 1'h1;
    cyc(40);
    chk("free", free_run, 16'h0);
    cyc(30);
    chk("free", free_run, 16'h1);
    chk("reason", reason, 16'h4);
    cyc(2);
    chk("tx", tx_enable, 16'h0);
  endtask
  task automatic t_back();
    int pulses;
    fault = 16'h0;
    loop_timed = 1'h0;
    ref_enable = 4'hE;
    primary = 2'h2;
    cyc(110);
    chk("free", free_run, 16'h0);
    chk("active", active, 16'h2);
    chk("failed", failed, 16'h1);
    chk("reason", reason, 16'h0);
    chk("tx", tx_enable, 16'h1);
    chk("freq", freq, 16'h3);
    pulses = 0;
    mode_change = 1'h1;
    cyc(1);
    mode_change = 1'h0;
    repeat (3)
    begin
      pulses += int'(build_out);
      cyc(1);
    end
    chk("build", 16'(pulses), 16'h1);
  endtask
  task automatic t_freeze();
    ce = 1'h0;
    steer = 16'h5;
    cyc(20);
    chk("freq", freq, 16'h3);
    ce = 1'h1;
    cyc(20);
    chk("freq", freq, 16'h5);
  endtask
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial
  begin
    cyc(10);
    reset = 1'h0;
    cyc(3);
    chk("free", free_run, 16'h0);
    t_jitter();
    t_hit();
    t_los();
    t_ber();
    t_back();
    t_freeze();
    conclude();
  end
endmodule // tb
